// ---- core/clockgen_cfg_host.sv ----
// Purpose: host that programs the clock generator configuration
//          port over two open-drain lines, ordered from Avalon-MM.
// Assumes: 40 MHz clk_sys; pins resolved by the board or bench.
// Notes:   a 16-byte window holds write data and read results.
//
// Operation
// - Bit rate stays at or below 400k
// - Write: start, address, pointer, data, stop
// - Start: data falls while clock high
// - Stop: data rises while clock high
// - Data changes only while clock low
// - Single write: pointer, one byte, stop
// - Read sends address with direction one
// - Last read byte unacknowledged, then stop
// - Random read: pointer, repeated start, read
// - Acknowledged read bytes continue the sequence
// - 2.5 V supply needs 7F and 90
// - Registers programmable in any order
// - Mixed bytes written once, fully composed
`timescale 1ns/1ps

module clockgen_cfg_host
(
	input  wire logic        clk_sys,
	input  wire logic        reset,
	input  wire logic [6:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        scl_in,
	output logic             scl_out,
	output logic             scl_oe_n,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe_n
);
	typedef enum {S_IDLE, S_START, S_ADDR, S_PTR, S_DATA,
	              S_RSTART, S_RADDR, S_READ, S_STOP} seq_state_t;

	// Link to the bit engine
	byte_link_if link ();

	// Bus slave state
	logic                  wait_reg;     // Waitrequest flop
	logic [31:0]           rdata_reg;    // Read data flop
	// Software settings
	clkgen_cfg_pkg::op_t   op_reg;       // Operation to run
	logic [6:0]            target_reg;   // Target address
	logic [7:0]            pointer_reg;  // Start register pointer
	logic [3:0]            length_reg;   // Byte count minus one
	// Sequencer state
	seq_state_t            state_reg;    // Frame step
	seq_state_t            state_next;   // Next frame step
	logic                  pend_reg;     // Command outstanding
	logic [3:0]            idx_reg;      // Byte index in window
	logic                  pass_reg;     // Second supply frame
	logic                  done_reg;     // Sticky finished flag
	logic                  nack_reg;     // Sticky refusal flag
	logic [7:0]            dev_ptr_reg;  // Copy of target counter
	logic [7:0]            mem [clkgen_cfg_pkg::DATA_WORDS]; // Data window

	// Decode wires
	logic [6:0]  reg_addr;   // Word-aligned offset
	logic        is_data;    // Data window selected
	logic [3:0]  data_idx;   // Window word index
	logic        bus_take;   // Request seen, answer next cycle
	logic        wr_take;    // Write completes this edge
	logic        busy;       // Frame in progress
	logic        go;         // Start request accepted
	logic        cfg_wr;     // Settings write allowed
	logic        step_done;  // Engine finished our command
	logic        eng_nack;   // Ninth bit was high
	logic        byte_nack;  // Refused byte in a write step
	logic        supply;     // Supply preset operation
	logic [3:0]  last_idx;   // Index of the last byte
	logic        at_last;    // Current byte is the last
	logic        dir_bit;    // Direction bit to send
	logic [7:0]  ptr_eff;    // Pointer sent on the line
	logic [7:0]  wdata_eff;  // Data byte sent on the line
	logic [31:0] reg_word;   // Selected register value
	logic [31:0] rd_word;    // Value for read data

	// Bus decode
	assign reg_addr  = {avs_address[6:2], 2'b00};
	assign is_data   = avs_address[clkgen_cfg_pkg::DATA_SEL_BIT];
	assign data_idx  = avs_address[5:2];
	assign bus_take  = (avs_read || avs_write) && wait_reg;
	assign wr_take   = avs_write && !wait_reg;
	assign busy      = (state_reg != S_IDLE);
	assign cfg_wr    = wr_take && !busy && !is_data;
	assign go        = cfg_wr && (reg_addr == clkgen_cfg_pkg::REG_CTRL)
	                   && avs_writedata[clkgen_cfg_pkg::CTRL_GO_BIT];

	// Engine answers
	assign step_done = pend_reg && link.done;
	assign eng_nack  = (link.rx_bits[0] == clkgen_cfg_pkg::NACK);
	assign byte_nack = step_done && eng_nack && (state_reg == S_ADDR || state_reg == S_PTR
	                   || state_reg == S_DATA || state_reg == S_RADDR);

	// Supply preset uses two one-byte frames
	assign supply    = (op_reg == clkgen_cfg_pkg::OP_SUPPLY);
	assign last_idx  = supply ? 4'h0 : length_reg;
	assign at_last   = (idx_reg == last_idx);
	assign ptr_eff   = !supply ? pointer_reg : (pass_reg ? clkgen_cfg_pkg::SEC_SUPPLY_ADDR
	                                                     : clkgen_cfg_pkg::PRI_SUPPLY_ADDR);
	assign wdata_eff = !supply ? mem[idx_reg] : (pass_reg ? clkgen_cfg_pkg::SEC_SUPPLY_25V
	                                                      : clkgen_cfg_pkg::PRI_SUPPLY_25V);
	assign dir_bit   = (state_reg == S_RADDR || op_reg == clkgen_cfg_pkg::OP_CUR_READ)
	                   ? clkgen_cfg_pkg::DIR_READ : clkgen_cfg_pkg::DIR_WRITE;

	// Command to the engine, offered once per step
	assign link.cmd_valid = busy && !pend_reg;
	assign link.cmd = (state_reg == S_START || state_reg == S_RSTART) ? clkgen_cfg_pkg::CMD_START
	                  : (state_reg == S_STOP) ? clkgen_cfg_pkg::CMD_STOP : clkgen_cfg_pkg::CMD_BYTE;
	assign link.tx_bits = (state_reg == S_ADDR || state_reg == S_RADDR)
	                      ? {target_reg, dir_bit, clkgen_cfg_pkg::NACK}
	                      : (state_reg == S_PTR) ? {ptr_eff, clkgen_cfg_pkg::NACK}
	                      : (state_reg == S_DATA) ? {wdata_eff, clkgen_cfg_pkg::NACK}
	                      : {8'hff, at_last ? clkgen_cfg_pkg::NACK : clkgen_cfg_pkg::ACK};

	// Register read mux, unmapped offsets read zero
	assign reg_word = (reg_addr == clkgen_cfg_pkg::REG_CTRL)    ? {30'h0, op_reg}
	                : (reg_addr == clkgen_cfg_pkg::REG_TARGET)  ? {25'h0, target_reg}
	                : (reg_addr == clkgen_cfg_pkg::REG_POINTER) ? {24'h0, pointer_reg}
	                : (reg_addr == clkgen_cfg_pkg::REG_LENGTH)  ? {28'h0, length_reg}
	                : (reg_addr == clkgen_cfg_pkg::REG_STATUS)  ? {29'h0, nack_reg, done_reg, busy}
	                : (reg_addr == clkgen_cfg_pkg::REG_DEV_PTR) ? {24'h0, dev_ptr_reg}
	                : 32'h0;
	assign rd_word  = is_data ? {24'h0, mem[data_idx]} : reg_word;

	// Bus handshake: one wait cycle, then the answer
	always_ff @(posedge clk_sys or posedge reset)
		if (reset)
		begin
			wait_reg  <= 1'b1;
			rdata_reg <= 32'h0;
		end
		else
		begin
			wait_reg <= !bus_take;
			if (bus_take && avs_read)
				rdata_reg <= rd_word;
		end
	assign avs_waitrequest = wait_reg;
	assign avs_readdata    = rdata_reg;

	// Settings, locked while a frame runs
	always_ff @(posedge clk_sys or posedge reset)
		if (reset)
		begin
			op_reg      <= clkgen_cfg_pkg::OP_WRITE;
			target_reg  <= clkgen_cfg_pkg::TARGET_RST;
			pointer_reg <= 8'h00;
			length_reg  <= 4'h0;
		end
		else if (cfg_wr)
			case (reg_addr)
				clkgen_cfg_pkg::REG_CTRL:    op_reg      <= clkgen_cfg_pkg::op_t'(avs_writedata[1:0]);
				clkgen_cfg_pkg::REG_TARGET:  target_reg  <= avs_writedata[6:0];
				clkgen_cfg_pkg::REG_POINTER: pointer_reg <= avs_writedata[7:0];
				clkgen_cfg_pkg::REG_LENGTH:  length_reg  <= avs_writedata[3:0];
				default:                     op_reg      <= op_reg;
			endcase

	// Frame steps
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			S_IDLE:
				if (go)
					state_next = S_START;
			S_START:
				if (step_done)
					state_next = S_ADDR;
			S_ADDR:
				if (step_done)
					state_next = eng_nack ? S_STOP
					             : (op_reg == clkgen_cfg_pkg::OP_CUR_READ) ? S_READ : S_PTR;
			S_PTR:
				if (step_done)
					state_next = eng_nack ? S_STOP
					             : (op_reg == clkgen_cfg_pkg::OP_RAND_READ) ? S_RSTART : S_DATA;
			S_DATA:
				if (step_done)
					state_next = (eng_nack || at_last) ? S_STOP : S_DATA;
			S_RSTART:
				if (step_done)
					state_next = S_RADDR;
			S_RADDR:
				if (step_done)
					state_next = eng_nack ? S_STOP : S_READ;
			S_READ:
				if (step_done && at_last)
					state_next = S_STOP;
			S_STOP:
				if (step_done)
					state_next = (supply && !pass_reg) ? S_START : S_IDLE;
			default:
				state_next = S_IDLE;
		endcase
	end

	// Sequencer registers
	always_ff @(posedge clk_sys or posedge reset)
		if (reset)
		begin
			state_reg   <= S_IDLE;
			pend_reg    <= 1'b0;
			idx_reg     <= 4'h0;
			pass_reg    <= 1'b0;
			done_reg    <= 1'b0;
			nack_reg    <= 1'b0;
			dev_ptr_reg <= 8'h00;
		end
		else
		begin
			state_reg <= state_next;
			pend_reg  <= busy && (pend_reg ? !link.done : 1'b1);
			if (go)
			begin
				pass_reg <= 1'b0;
				done_reg <= 1'b0;
				nack_reg <= 1'b0;
			end
			if (byte_nack)
				nack_reg <= 1'b1;
			if (state_reg == S_START)
				idx_reg <= 4'h0;
			if (step_done && (state_reg == S_DATA || state_reg == S_READ))
				idx_reg <= idx_reg + 4'h1;
			if (step_done && state_reg == S_PTR && !eng_nack)
				dev_ptr_reg <= ptr_eff;
			if (step_done && ((state_reg == S_DATA && !eng_nack) || state_reg == S_READ))
				dev_ptr_reg <= dev_ptr_reg + 8'h01;
			if (step_done && state_reg == S_STOP && supply)
				pass_reg <= 1'b1;
			if (step_done && state_reg == S_STOP && state_next == S_IDLE)
				done_reg <= 1'b1;
		end

	// Data window: software fills it idle, reads fill it busy
	always_ff @(posedge clk_sys or posedge reset)
		if (reset)
		begin
			for (int i = 0; i < clkgen_cfg_pkg::DATA_WORDS; i++)
				mem[i] <= 8'h00;
		end
		else if (wr_take && !busy && is_data)
			mem[data_idx] <= avs_writedata[7:0];
		else if (step_done && state_reg == S_READ)
			mem[idx_reg] <= link.rx_bits[8:1];

	// Bit engine
	i2c_byte_engine u_engine
	(
		.clk_sys  (clk_sys),
		.reset    (reset),
		.link     (link.eng),
		.scl_in   (scl_in),
		.scl_out  (scl_out),
		.scl_oe_n (scl_oe_n),
		.sda_in   (sda_in),
		.sda_out  (sda_out),
		.sda_oe_n (sda_oe_n)
	);

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);
	start_then_addr_a : assert property (state_reg == S_START && step_done |=> state_reg == S_ADDR)
		else $error("start not followed by address");
	read_dir_a : assert property (state_reg == S_RADDR |-> link.tx_bits[1] == clkgen_cfg_pkg::DIR_READ)
		else $error("read address without read direction");
	last_read_nack_a : assert property (state_reg == S_READ && at_last |-> link.tx_bits[0])
		else $error("last read byte acknowledged");
	mid_read_ack_a : assert property (state_reg == S_READ && !at_last |-> !link.tx_bits[0])
		else $error("middle read byte refused");
	rand_rstart_a : assert property (state_reg == S_PTR && step_done && !eng_nack
		&& op_reg == clkgen_cfg_pkg::OP_RAND_READ |=> state_reg == S_RSTART)
		else $error("random read without repeated start");
	single_stop_a : assert property (state_reg == S_DATA && step_done && at_last |=> state_reg == S_STOP)
		else $error("no stop after last data byte");
	ptr_wrap_a : assert property (state_reg == S_READ && step_done
		|=> dev_ptr_reg == 8'($past(dev_ptr_reg) + 8'h01))
		else $error("pointer copy did not advance");
	bus_answer_a : assert property (bus_take |=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("bus answer not one cycle");
	done_idle_a : assert property ($rose(done_reg) |-> !busy && !$past(busy, 2) == 1'b0)
		else $error("done raised outside frame end");
endmodule : clockgen_cfg_host

// ---- inc/clkgen_cfg_pkg.sv ----
// Purpose: shared constants and types for the clock generator
//          configuration host.
// Assumes: 40 MHz system clock.
// Notes:   timing counts derive from nanosecond figures.
package clkgen_cfg_pkg;
	// System clock period
	localparam int CLK_NS      = 25;
	// Serial bus limits
	localparam int SCL_MAX_KHZ = 400;
	localparam int T_LOW_NS    = 1300;
	localparam int T_HIGH_NS   = 600;
	localparam int T_BUF_NS    = 1300;
	// Whole bit period, rounded up to keep under the rate limit
	localparam int BIT_CYC = (1000000 / SCL_MAX_KHZ + CLK_NS - 1) / CLK_NS;
	// Clock low time, rounded up
	localparam logic [7:0] LOW_CYC   = 8'((T_LOW_NS + CLK_NS - 1) / CLK_NS);
	// Data changes in the middle of the low time
	localparam logic [7:0] LOW_HALF  = LOW_CYC >> 1;
	// High time fills the rest of the bit period
	localparam logic [7:0] HIGH_CYC  = 8'(BIT_CYC) - LOW_CYC;
	// Start hold and stop setup, also the sample point
	localparam logic [7:0] HIGH_HOLD = 8'((T_HIGH_NS + CLK_NS - 1) / CLK_NS);
	// Bus free time after a stop
	localparam logic [7:0] BUF_CYC   = 8'((T_BUF_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] STOP_END  = HIGH_HOLD + BUF_CYC;
	// Software register byte offsets
	localparam logic [6:0] REG_CTRL    = 7'h00;
	localparam logic [6:0] REG_TARGET  = 7'h04;
	localparam logic [6:0] REG_POINTER = 7'h08;
	localparam logic [6:0] REG_LENGTH  = 7'h0c;
	localparam logic [6:0] REG_STATUS  = 7'h10;
	localparam logic [6:0] REG_DEV_PTR = 7'h14;
	// Address bit that selects the data window
	localparam int DATA_SEL_BIT = 6;
	localparam int DATA_WORDS   = 16;
	// Field positions
	localparam int CTRL_GO_BIT = 4;
	localparam int STAT_BUSY   = 0;
	localparam int STAT_DONE   = 1;
	localparam int STAT_NACK   = 2;
	// Default target address
	localparam logic [6:0] TARGET_RST = 7'h47;
	// Device map: supply setting registers
	localparam logic [7:0] PRI_SUPPLY_ADDR = 8'h41;
	localparam logic [7:0] SEC_SUPPLY_ADDR = 8'h43;
	localparam logic [7:0] PRI_SUPPLY_RST  = 8'hbf;
	localparam logic [7:0] SEC_SUPPLY_RST  = 8'ha0;
	localparam logic [7:0] PRI_SUPPLY_25V  = 8'h7f;
	localparam logic [7:0] SEC_SUPPLY_25V  = 8'h90;
	// Line levels
	localparam logic DIR_WRITE = 1'b0;
	localparam logic DIR_READ  = 1'b1;
	localparam logic ACK       = 1'b0;
	localparam logic NACK      = 1'b1;
	// Software operations
	typedef enum logic [1:0] {OP_WRITE, OP_CUR_READ, OP_RAND_READ, OP_SUPPLY} op_t;
	// Engine commands
	typedef enum logic [1:0] {CMD_START, CMD_STOP, CMD_BYTE} cmd_t;
endpackage : clkgen_cfg_pkg

// ---- inc/byte_link_if.sv ----
// Purpose: command link between sequencer and bit engine.
// Assumes: sequencer issues only while the engine is idle.
// Notes:   tx_bits[0] is the ninth bit, 1 releases the line.
`timescale 1ns/1ps

interface byte_link_if;
	logic                  cmd_valid; // Command offered
	clkgen_cfg_pkg::cmd_t  cmd;       // Start, stop or byte
	logic [8:0]            tx_bits;   // Bits sent, msb first
	logic                  done;      // Command finished
	logic [8:0]            rx_bits;   // Bits sampled on the line
	modport seq (output cmd_valid, output cmd, output tx_bits, input done, input rx_bits);
	modport eng (input cmd_valid, input cmd, input tx_bits, output done, output rx_bits);
endinterface : byte_link_if

// ---- core/i2c_byte_engine.sv ----
// Purpose: drives the serial clock and data lines one slot at a time.
// Assumes: open-drain pins; enable low pulls the line low.
// Notes:   holds the clock high until the line is seen high.
`timescale 1ns/1ps

module i2c_byte_engine
(
	input  wire logic clk_sys,
	input  wire logic reset,
	byte_link_if.eng  link,
	input  wire logic scl_in,
	output logic      scl_out,
	output logic      scl_oe_n,
	input  wire logic sda_in,
	output logic      sda_out,
	output logic      sda_oe_n
);
	typedef enum {E_IDLE, E_LOW, E_HIGH} eng_state_t;
	eng_state_t           state_reg;  // Slot phase
	clkgen_cfg_pkg::cmd_t kind_reg;   // Command in progress
	logic [7:0]           cnt_reg;    // Cycles in phase
	logic [3:0]           slot_reg;   // Slots still to go
	logic [8:0]           shift_reg;  // Bits to send
	logic [8:0]           rx_reg;     // Bits sampled
	logic                 done_reg;   // Finish pulse
	logic                 scl_s1, scl_s2, sda_s1, sda_s2;
	logic [7:0]           high_end;   // Length of high phase
	logic                 low_cnt_ok; // Low time checker

	// Stop slot stays high through the bus free time
	assign high_end     = (kind_reg == clkgen_cfg_pkg::CMD_STOP) ? clkgen_cfg_pkg::STOP_END
	                                                             : clkgen_cfg_pkg::HIGH_CYC;
	assign link.done    = done_reg;
	assign link.rx_bits = rx_reg;

	// Pin synchronisers
	always_ff @(posedge clk_sys or posedge reset)
		if (reset)
		begin
			scl_s1 <= 1'b1;
			scl_s2 <= 1'b1;
			sda_s1 <= 1'b1;
			sda_s2 <= 1'b1;
		end
		else
		begin
			scl_s1 <= scl_in;
			scl_s2 <= scl_s1;
			sda_s1 <= sda_in;
			sda_s2 <= sda_s1;
		end

	// Slot sequencer
	always_ff @(posedge clk_sys or posedge reset)
		if (reset)
		begin
			state_reg <= E_IDLE;
			kind_reg  <= clkgen_cfg_pkg::CMD_STOP;
			cnt_reg   <= 8'h00;
			slot_reg  <= 4'h0;
			shift_reg <= 9'h1ff;
			rx_reg    <= 9'h1ff;
			done_reg  <= 1'b0;
			scl_out   <= 1'b0;
			sda_out   <= 1'b0;
			scl_oe_n  <= 1'b1;
			sda_oe_n  <= 1'b1;
		end
		else
		begin
			done_reg <= 1'b0;
			case (state_reg)
				// Take a command, pull the clock low
				E_IDLE:
					if (link.cmd_valid)
					begin
						kind_reg  <= link.cmd;
						shift_reg <= (link.cmd == clkgen_cfg_pkg::CMD_BYTE) ? link.tx_bits
						             : {link.cmd == clkgen_cfg_pkg::CMD_START, 8'h00};
						slot_reg  <= (link.cmd == clkgen_cfg_pkg::CMD_BYTE) ? 4'h8 : 4'h0;
						cnt_reg   <= 8'h00;
						scl_oe_n  <= 1'b0;
						state_reg <= E_LOW;
					end
				E_LOW:
				begin
					cnt_reg <= cnt_reg + 8'h01;
					if (cnt_reg == clkgen_cfg_pkg::LOW_HALF - 8'h01)
						sda_oe_n <= shift_reg[8];
					if (cnt_reg == clkgen_cfg_pkg::LOW_CYC - 8'h01)
					begin
						scl_oe_n  <= 1'b1;
						cnt_reg   <= 8'h00;
						state_reg <= E_HIGH;
					end
				end
				E_HIGH:
					// Count only once the clock is really high
					if (scl_s2)
					begin
						cnt_reg <= cnt_reg + 8'h01;
						if (cnt_reg == clkgen_cfg_pkg::HIGH_HOLD - 8'h01)
						begin
							rx_reg <= {rx_reg[7:0], sda_s2};
							if (kind_reg == clkgen_cfg_pkg::CMD_START)
								sda_oe_n <= 1'b0;
							if (kind_reg == clkgen_cfg_pkg::CMD_STOP)
								sda_oe_n <= 1'b1;
						end
						if (cnt_reg == high_end - 8'h01)
						begin
							cnt_reg <= 8'h00;
							if (kind_reg != clkgen_cfg_pkg::CMD_STOP)
								scl_oe_n <= 1'b0;
							if (slot_reg == 4'h0 || kind_reg == clkgen_cfg_pkg::CMD_STOP)
							begin
								done_reg  <= 1'b1;
								state_reg <= E_IDLE;
							end
							else
							begin
								slot_reg  <= slot_reg - 4'h1;
								shift_reg <= {shift_reg[7:0], 1'b1};
								state_reg <= E_LOW;
							end
						end
					end
				default:
					state_reg <= E_IDLE;
			endcase
		end

	// Helper: clock low time seen so far
	logic [7:0] low_seen;
	always_ff @(posedge clk_sys or posedge reset)
		if (reset)
			low_seen <= 8'h00;
		else
			low_seen <= scl_oe_n ? 8'h00 : ((low_seen == 8'hff) ? low_seen : low_seen + 8'h01);
	assign low_cnt_ok = (low_seen >= clkgen_cfg_pkg::LOW_CYC);

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);
	data_in_low_a : assert property ($changed(sda_oe_n) && scl_oe_n |-> kind_reg != clkgen_cfg_pkg::CMD_BYTE)
		else $error("data moved while clock high");
	start_fall_a : assert property ($fell(sda_oe_n) && scl_oe_n |-> kind_reg == clkgen_cfg_pkg::CMD_START)
		else $error("data fell high outside start");
	stop_rise_a : assert property ($rose(sda_oe_n) && scl_oe_n |-> kind_reg == clkgen_cfg_pkg::CMD_STOP)
		else $error("data rose high outside stop");
	scl_low_time_a : assert property ($rose(scl_oe_n) |-> low_cnt_ok)
		else $error("clock low time too short");
endmodule : i2c_byte_engine

// ---- sim/cfg_target_model.sv ----
// Purpose: behavioural configuration target on the two-wire bus.
// Assumes: the bench resolves both lines with pull-ups.
// Notes: oe_n low pulls the data line low.
`timescale 1ns/1ps

module cfg_target_model
(
	input  wire logic scl,
	input  wire logic sda,
	output logic      oe_n
);
	logic [7:0] mem [256]; // Register space
	logic [7:0] ptr;       // Address counter
	logic [7:0] sh;        // Received bits
	logic [7:0] rd;        // Byte being sent
	int         st;        // 0 idle, 1 addr, 2 ptr, 3 write, 4 read
	int         cnt;       // Clock rises in this byte
	initial
	begin
		for (int i = 0; i < 256; i++)
			mem[i] = 8'(i) ^ 8'h5a;
		mem[8'h41] = 8'hbf;
		mem[8'h43] = 8'ha0;
		mem[8'h48] = 8'h80;
		ptr = 8'h00;
		st = 0;
		oe_n = 1'b1;
	end
	always @(negedge sda)
		if (scl)
		begin
			st = 1;
			cnt = 0;
		end
	always @(posedge sda)
		if (scl)
		begin
			st = 0;
			oe_n = 1'b1;
		end
	// sample while clock high, nack ends read
	always @(posedge scl)
		if (st != 0)
		begin
			if (cnt < 8)
				sh = {sh[6:0], sda};
			else if (st == 4 && sda)
				st = 0;
			cnt = cnt + 1;
		end
	always @(negedge scl)
		if (st != 0)
		begin
			#100;
			if (cnt == 8)
			begin
				oe_n = (st == 4 || (st == 1 && sh[7:1] != 7'h47));
				if (st == 1)
					st = (sh[7:1] != 7'h47) ? 0 : (sh[0] ? 4 : 2);
				else if (st == 2)
					{ptr, st} = {sh, 32'd3};
				else if (st == 3)
					{mem[ptr], ptr} = {sh, ptr + 8'h01};
			end
			else if (cnt == 9)
			begin
				cnt = 0;
				oe_n = 1'b1;
				if (st == 4)
					{rd, ptr, oe_n} = {mem[ptr], ptr + 8'h01, mem[ptr][7]};
			end
			else if (st == 4)
				oe_n = rd[7 - cnt];
		end
endmodule : cfg_target_model

// ---- sim/test_clockgen_cfg_host.sv ----
// Purpose: self-checking bench for the configuration host.
// Assumes: target model at address 47H on pulled-up lines.
// Notes: a reference byte map predicts every read.
`timescale 1ns/1ps

module test_clockgen_cfg_host;
	logic        clk_sys, reset, avs_read, avs_write, avs_waitrequest;
	logic        scl_out, scl_oe_n, sda_out, sda_oe_n, tgt_oe_n;
	logic [6:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata, q, seed;
	int          mismatches, total_checks, cycles, ptr;
	int          mem [256]; // Expected device contents
	wire         sda_line = sda_oe_n & tgt_oe_n; // Open-drain wired and
	clockgen_cfg_host dut (.clk_sys(clk_sys), .reset(reset), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .scl_in(scl_oe_n),
		.scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n));
	cfg_target_model target (.scl(scl_oe_n), .sda(sda_line), .oe_n(tgt_oe_n));
	initial
	begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	// One Avalon access, held until waitrequest is seen low
	task automatic bus(input logic wr, input logic [6:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		{avs_address, avs_writedata, avs_write, avs_read} <= {a, d, wr, ~wr};
		// Wait for the answer; a stuck slave ends in the hang guard
		do
			@(posedge clk_sys);
		while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : bus
	// Start an operation and wait for done
	task automatic run(input int op, input int tgt, input int p, input int len, input logic nk);
		int n;
		bus(1, clkgen_cfg_pkg::REG_TARGET, tgt);
		bus(1, clkgen_cfg_pkg::REG_POINTER, p);
		bus(1, clkgen_cfg_pkg::REG_LENGTH, len - 1);
		bus(1, clkgen_cfg_pkg::REG_CTRL, 32'h10 | op);
		n = 0;
		do
		begin
			bus(0, clkgen_cfg_pkg::REG_STATUS, 0);
			n++;
		end
		while (q[1] !== 1'b1 && n < 30000);
		check("status", q[2:0], {nk, 2'b10});
		check("lines", {scl_out, sda_out, scl_oe_n, sda_oe_n}, 4'b0011);
		bus(0, clkgen_cfg_pkg::REG_DEV_PTR, 0);
		if (!nk)
			check("dev_ptr", q, ptr);
	endtask : run
	// Read op 1 or 2 and compare the window with the map
	task automatic readback(input int op, input int p, input int len);
		int b;
		b = (op == 1) ? ptr : p;
		ptr = (b + len) % 256;
		run(op, 7'h47, p, len, 1'b0);
		for (int i = 0; i < len; i++)
		begin
			bus(0, 7'(32'h40 + 4 * i), 0);
			check("window", q, mem[(b + i) % 256]);
		end
	endtask : readback
	task automatic test_done;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : test_done
	// Hang guard
	always @(posedge clk_sys)
	begin
		cycles <= cycles + 1;
		if (cycles == 90000)
		begin
			mismatches++;
			test_done();
		end
	end
	initial
	begin
		{reset, avs_read, avs_write, avs_address, avs_writedata} = {1'b1, 41'h0};
		{mismatches, total_checks, cycles, ptr} = '0;
		seed = 32'h8d6f104c;
		for (int i = 0; i < 256; i++)
			mem[i] = i ^ 8'h5a;
		{mem[8'h41], mem[8'h43], mem[8'h48]} = {32'hbf, 32'ha0, 32'h80};
		repeat (8) @(posedge clk_sys);
		reset <= 1'b0;
		bus(0, 7'h1c, 0);
		check("unmapped", q, 32'h0);
		readback(2, 8'h41, 8);
		// Random bytes written across the top of the map
		for (int i = 0; i < 16; i++)
		begin
			seed = xs(seed);
			mem[(8'hf8 + i) % 256] = seed[7:0];
			bus(1, 7'(32'h40 + 4 * i), {24'h0, seed[7:0]});
		end
		ptr = 8'h08;
		run(0, 7'h47, 8'hf8, 16, 1'b0);
		readback(1, 0, 5);
		readback(2, 8'hf8, 16);
		{mem[8'h41], mem[8'h43], ptr} = {32'h7f, 32'h90, 32'h44};
		run(3, 7'h47, 0, 1, 1'b0);
		readback(2, 8'h41, 3);
		run(0, 7'h46, 0, 1, 1'b1);
		readback(1, 0, 1);
		test_done();
	end
endmodule : test_clockgen_cfg_host
